// file: sdlc_pkg.sv
`default_nettype none
package sdlc_pkg;
    localparam int SDLC_WORD_W = 16;
    localparam int SDLC_CODE_W = 12;
    localparam int SDLC_CNT_W = 5;
    localparam logic [4:0] SDLC_LAST_BIT = 5'h0F;
    localparam logic [11:0] SDLC_CODE_RST = 12'h000;
    localparam int SDLC_BUF_DEPTH = 2;
    typedef struct packed {
        logic sclk;
        logic sdata;
        logic sync_n;
        logic load_n;
        logic clear_n;
    } sdlc_pins_t;
    typedef enum logic [1:0] {
        SDLC_IDLE = 2'b00,
        SDLC_SHIFT = 2'b01,
        SDLC_DONE = 2'b10
    } sdlc_state_t;
endpackage
`default_nettype wire

// file: sdlc_buf.sv
`default_nettype none
module sdlc_buf
    import sdlc_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // Pointers are one bit wide, so only a two-entry store is served
    if (DEPTH != 2) begin : g_bad_depth
        $error("sdlc_buf supports DEPTH 2 only");
    end
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic wr_ptr_ff;
    logic rd_ptr_ff;
    logic [1:0] cnt_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data = mem_ff[rd_ptr_ff];
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            if (push) wr_ptr_ff <= ~wr_ptr_ff;
            if (pop) rd_ptr_ff <= ~rd_ptr_ff;
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
    always_ff @(posedge clk_sys) begin
        if (push) mem_ff[wr_ptr_ff] <= in_data;
    end
endmodule
`default_nettype wire

// file: sdlc_top.sv
`default_nettype none
module sdlc_top
    import sdlc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic sync_n,
    input wire logic load_output_n,
    input wire logic clear_latch_n,
    input wire logic chain_enable,
    input wire logic code_format_select,
    input wire logic code_ready,
    output logic chain_out,
    output logic [SDLC_CODE_W-1:0] latch_code,
    output logic code_valid,
    output logic [SDLC_CODE_W-1:0] code_data
);
    sdlc_pins_t meta_ff;
    sdlc_pins_t pin_ff;
    sdlc_pins_t prev_ff;
    logic [SDLC_WORD_W-1:0] shreg_ff;
    logic [SDLC_CNT_W-1:0] bitcnt_ff;
    logic [SDLC_CODE_W-1:0] latch_ff;
    logic chain_ff;
    logic fmt_ff;
    logic [1:0] strap_meta_ff;
    logic [1:0] prime_ff;
    sdlc_state_t state_ff;
    sdlc_state_t nxt_state;
    logic [SDLC_WORD_W-1:0] nxt_shreg;
    function automatic logic fell(input logic was_level, input logic now_level);
        return was_level && !now_level;
    endfunction
    // The counter must pass one beyond the last bit, and the code must fit the word
    if (SDLC_CODE_W > SDLC_WORD_W || SDLC_WORD_W >= (1 << SDLC_CNT_W)
            || SDLC_WORD_W != int'(SDLC_LAST_BIT) + 1) begin : g_bad_sizes
        $error("sdlc_top word, code and counter sizes disagree");
    end
    // A pin tied low would otherwise look like a falling edge straight after reset,
    // so edges count only once the synchroniser holds real samples
    wire primed = (prime_ff == 2'h3);
    wire sclk_fall = primed && fell(prev_ff.sclk, pin_ff.sclk);
    wire load_fall = primed && fell(prev_ff.load_n, pin_ff.load_n);
    wire [SDLC_CNT_W-1:0] cnt_full = SDLC_LAST_BIT + 5'h01;
    wire in_frame = !pin_ff.sync_n;
    wire shift_en = in_frame && sclk_fall;
    // Auto update needs the strobe tied low; chain mode waits for the strobe instead
    wire auto_upd = shift_en && pin_ff.load_n == 1'b0 && bitcnt_ff == SDLC_LAST_BIT && !chain_ff;
    wire strobe_upd = load_fall && !in_frame;
    wire do_update = pin_ff.clear_n && (auto_upd || strobe_upd);
    wire [SDLC_CODE_W-1:0] new_code = nxt_shreg[SDLC_CODE_W-1:0];
    wire [SDLC_CODE_W-1:0] upd_code = auto_upd ? new_code : shreg_ff[SDLC_CODE_W-1:0];
    wire buf_ready;
    // Oldest bit climbs to the top, so the last bit shifted is the code's LSB
    assign nxt_shreg = {shreg_ff[SDLC_WORD_W-2:0], pin_ff.sdata};
    // DONE only marks a finished frame until sync rises; the saturating bit count is what holds off a second update
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SDLC_IDLE: if (in_frame) nxt_state = SDLC_SHIFT;
            SDLC_SHIFT: begin
                if (!in_frame) nxt_state = SDLC_IDLE;
                else if (auto_upd) nxt_state = SDLC_DONE;
            end
            SDLC_DONE: if (!in_frame) nxt_state = SDLC_IDLE;
            default: nxt_state = SDLC_IDLE;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_ff <= '1;
            pin_ff <= '1;
            prev_ff <= '1;
        end else begin
            meta_ff <= '{sclk, sdata, sync_n, load_output_n, clear_latch_n};
            pin_ff <= meta_ff;
            prev_ff <= pin_ff;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) prime_ff <= 2'h0;
        else if (!primed) prime_ff <= prime_ff + 2'h1;
    end
    // Straps pass two flops and are taken only between frames, so a mode change never splits a word
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            strap_meta_ff <= 2'h0;
            chain_ff <= 1'b0;
            fmt_ff <= 1'b0;
        end else begin
            strap_meta_ff <= {chain_enable, code_format_select};
            if (state_ff == SDLC_IDLE) begin
                chain_ff <= strap_meta_ff[1];
                fmt_ff <= strap_meta_ff[0];
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= SDLC_IDLE;
            shreg_ff <= '0;
            bitcnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            if (!in_frame) bitcnt_ff <= '0;
            // Saturates so a long chain frame cannot reach the sixteenth count twice
            else if (shift_en && bitcnt_ff != cnt_full) bitcnt_ff <= bitcnt_ff + 5'h01;
            if (shift_en) shreg_ff <= nxt_shreg;
        end
    end
    // Clear outranks every update, as the latch must read zero while it is held
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            latch_ff <= SDLC_CODE_RST;
        end else if (!pin_ff.clear_n) begin
            latch_ff <= SDLC_CODE_RST;
        end else if (do_update) begin
            latch_ff <= upd_code;
        end
    end
    // Bit leaving the register shows up on the chain output
    always_ff @(posedge clk_sys) begin
        if (rst) chain_out <= 1'b0;
        else chain_out <= chain_ff ? shreg_ff[SDLC_WORD_W-1] : 1'b0;
    end
    assign latch_code = latch_ff;
    // Each latched code is also streamed out; a full buffer drops it since the latch itself is authoritative
    sdlc_buf #(
        .WIDTH(SDLC_CODE_W),
        .DEPTH(SDLC_BUF_DEPTH)
    ) u_buf (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(do_update),
        .in_ready(buf_ready),
        .in_data(fmt_ff ? upd_code : upd_code),
        .out_valid(code_valid),
        .out_ready(code_ready),
        .out_data(code_data)
    );
    sequence s_frame_edge;
        pin_ff.clear_n ##0 auto_upd;
    endsequence
    sequence s_load_edge;
        strobe_upd ##0 pin_ff.clear_n;
    endsequence
    sequence s_sixteenth;
        shift_en ##0 bitcnt_ff == SDLC_LAST_BIT;
    endsequence
    auto_update_a: assert property (@(posedge clk_sys) disable iff (rst)
        s_frame_edge |=> latch_ff == $past(new_code)) else $error("auto update wrong");
    clear_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
        !pin_ff.clear_n |=> latch_ff == SDLC_CODE_RST) else $error("clear failed");
    strobe_load_a: assert property (@(posedge clk_sys) disable iff (rst)
        s_load_edge |=> latch_ff == $past(shreg_ff[SDLC_CODE_W-1:0]))
        else $error("strobe load wrong");
    shift_in_a: assert property (@(posedge clk_sys) disable iff (rst)
        shift_en |=> shreg_ff[0] == $past(pin_ff.sdata)) else $error("shift sample wrong");
    hold_shift_a: assert property (@(posedge clk_sys) disable iff (rst)
        !shift_en |=> $stable(shreg_ff)) else $error("shift reg moved");
    chain_out_a: assert property (@(posedge clk_sys) disable iff (rst)
        chain_ff |=> chain_out == $past(shreg_ff[SDLC_WORD_W-1])) else $error("chain out wrong");
    chain_no_auto_a: assert property (@(posedge clk_sys) disable iff (rst)
        chain_ff && !strobe_upd && pin_ff.clear_n |=> $stable(latch_ff)) else $error("chain auto update");
    buf_push_a: assert property (@(posedge clk_sys) disable iff (rst)
        (do_update && buf_ready) |=> code_valid)
        else $error("code not queued");
    auto_push_a: assert property (@(posedge clk_sys) disable iff (rst)
        s_frame_edge |=> code_valid)
        else $error("auto code not streamed");
    out_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        (code_valid && !code_ready) |=> (code_valid && $stable(code_data)))
        else $error("stalled code moved");
    auto_done_a: assert property (@(posedge clk_sys) disable iff (rst)
        s_sixteenth ##0 !chain_ff ##0 !pin_ff.load_n |=> state_ff == SDLC_DONE)
        else $error("sixteenth edge missed");
    done_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        (state_ff == SDLC_DONE && in_frame) |=> state_ff == SDLC_DONE)
        else $error("second update armed");
    idle_exit_a: assert property (@(posedge clk_sys) disable iff (rst)
        !in_frame |=> state_ff == SDLC_IDLE)
        else $error("frame end missed");
    count_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        !in_frame |=> bitcnt_ff == 5'h00)
        else $error("bit count not cleared");
    count_step_a: assert property (@(posedge clk_sys) disable iff (rst)
        (shift_en && bitcnt_ff != cnt_full) |=> bitcnt_ff == $past(bitcnt_ff) + 5'h01)
        else $error("bit count step wrong");
    count_sat_a: assert property (@(posedge clk_sys) disable iff (rst)
        (bitcnt_ff == cnt_full) |=> (bitcnt_ff == cnt_full || bitcnt_ff == 5'h00))
        else $error("bit count wrapped");
    chain_ripple_a: assert property (@(posedge clk_sys) disable iff (rst)
        (chain_ff && shift_en) |=> shreg_ff[SDLC_WORD_W-1] == $past(shreg_ff[SDLC_WORD_W-2]))
        else $error("chain ripple wrong");
    chain_off_a: assert property (@(posedge clk_sys) disable iff (rst)
        !chain_ff |=> chain_out == 1'b0)
        else $error("chain out not quiet");
    strap_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        state_ff != SDLC_IDLE |=> $stable(chain_ff))
        else $error("chain strap moved in frame");
    hold_code_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!do_update && pin_ff.clear_n) |=> $stable(latch_ff))
        else $error("latch moved without update");
    shift_latch_a: assert property (@(posedge clk_sys) disable iff (rst)
        (shift_en && !do_update && pin_ff.clear_n) |=> $stable(latch_ff))
        else $error("shift disturbed latch");
endmodule
`default_nettype wire

// file: sdlc_host.sv
`default_nettype none
module sdlc_host (
    input wire logic clk_sys,
    output logic sclk,
    output logic sdata,
    output logic sync_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sclk = 1'b1;
        sdata = 1'b0;
        sync_n = 1'b1;
    end
    // Clock idles high between frames; one bit takes 8 clk_sys cycles
    task automatic frame(input logic [63:0] w, input int n);
        sync_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        for (int i = n - 1; i >= 0; i--) begin
            sdata <= w[i];
            repeat (4) @(posedge clk_sys);
            sclk <= 1'b0;
            repeat (4) @(posedge clk_sys);
            sclk <= 1'b1;
        end
        repeat (4) @(posedge clk_sys);
        sync_n <= 1'b1;
        sdata <= ~sdata; // Released line must not keep looking valid
    endtask
endmodule
`default_nettype wire

// file: serial_dac_load_chain_tb_top.sv
`default_nettype none
module serial_dac_load_chain_tb_top
    import sdlc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic load_n = 1'b0;
    logic clr_n = 1'b1;
    logic chain_en = 1'b0;
    logic fmt = 1'b0;
    logic code_ready = 1'b0;
    logic sclk, sdata, sync_n, chain_out, code_valid;
    logic [SDLC_CODE_W-1:0] latch_code, code_data;
    int n_mismatch = 0;
    int n_checks = 0;
    always #50 clk_sys = ~clk_sys;
    sdlc_host host (.clk_sys(clk_sys), .sclk(sclk), .sdata(sdata), .sync_n(sync_n));
    sdlc_top dut (.clk_sys(clk_sys), .rst(rst), .sclk(sclk), .sdata(sdata), .sync_n(sync_n),
        .load_output_n(load_n), .clear_latch_n(clr_n), .chain_enable(chain_en),
        .code_format_select(fmt), .code_ready(code_ready), .chain_out(chain_out),
        .latch_code(latch_code), .code_valid(code_valid), .code_data(code_data));
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Receiver stalls, so both words must wait in the buffer in order
    task automatic auto_update;
        host.frame(64'hA5C3, 16);
        repeat (4) @(posedge clk_sys);
        check("latch", latch_code, 12'h5C3);
        host.frame(64'h0F0E, 16);
        repeat (4) @(posedge clk_sys);
        check("latch", latch_code, 12'hF0E);
        check("head", code_data, 12'h5C3);
        code_ready <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check("valid", {11'h000, code_valid}, 12'h000);
    endtask
    task automatic clear_case;
        clr_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check("clear", latch_code, 12'h000);
        clr_n <= 1'b1;
    endtask
    task automatic chain_case;
        chain_en <= 1'b1;
        fmt <= 1'b1;
        load_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        host.frame(64'h9234_8ABC, 32);
        repeat (4) @(posedge clk_sys);
        check("no auto", latch_code, 12'h000);
        check("chain out", {11'h000, chain_out}, 12'h001);
        load_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check("load", latch_code, 12'hABC);
        load_n <= 1'b1;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        auto_update();
        clear_case();
        chain_case();
        tally_and_finish();
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
